//--- rtl/ptu_pkg.sv
// constants and carriers of the processor trap unit
package ptu_pkg;
    localparam int PTU_CLK_KHZ = 40000;
    localparam int PTU_HOLD_MS = 2;
    localparam int PTU_HOLD_CYC = PTU_HOLD_MS * PTU_CLK_KHZ;
    localparam int PTU_HOLD_W = 17;
    localparam int PTU_TMO_NS = 10000;
    localparam int PTU_TMO_CYC = (PTU_TMO_NS * (PTU_CLK_KHZ / 1000) + 999) / 1000;
    localparam int PTU_TMO_W = 9;
    // causes, index 0 is served first
    localparam int PTU_NCAUSE = 12;
    localparam int PTU_C_BUS = 0;
    localparam int PTU_C_STACK = 1;
    localparam int PTU_C_PARITY = 2;
    localparam int PTU_C_MMU = 3;
    localparam int PTU_C_FPU = 4;
    localparam int PTU_C_RSVD = 5;
    localparam int PTU_C_IOT = 6;
    localparam int PTU_C_EMT = 7;
    localparam int PTU_C_SWT = 8;
    localparam int PTU_C_BPT = 9;
    localparam int PTU_C_TRACE = 10;
    localparam int PTU_C_POWER = 11;
    localparam int PTU_CIDX_W = 4;
    // vector byte addresses (octal 4,4,114,250,244,10,20,30,34,14,14,24)
    localparam logic [15:0] PTU_VEC [PTU_NCAUSE] = '{
        16'h0004, 16'h0004, 16'h004C, 16'h00A8, 16'h00A4, 16'h0008,
        16'h0010, 16'h0018, 16'h001C, 16'h000C, 16'h000C, 16'h0014};
    localparam logic [15:0] PTU_OP_RTI = 16'h0002;
    localparam logic [15:0] PTU_OP_BPT = 16'h0003;
    localparam logic [15:0] PTU_OP_IOT = 16'h0004;
    localparam logic [15:0] PTU_OP_RTT = 16'h0006;
    localparam logic [7:0] PTU_OP_EMT_HI = 8'h88;
    localparam logic [7:0] PTU_OP_SWT_HI = 8'h89;
    localparam int PTU_PSW_TRACE = 4;
    localparam logic [15:0] PTU_WORD_STEP = 16'h0002;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ptu_mem_s;
    typedef struct packed {
        logic        load;
        logic [15:0] pc;
        logic [15:0] psw;
        logic [15:0] sp;
    } ptu_ctx_s;
    typedef struct packed {
        logic        start;
        logic        word;
        logic [15:0] addr;
        logic        ack;
    } ptu_bus_s;
endpackage : ptu_pkg

//--- rtl/ptu_trap_unit.sv
// processor trap unit: trap detection, state push, vector fetch and return pop
// How it works
// (RULE1) mains loss takes a trap through vector 24
// (RULE2) processor keeps running at least 2 ms after the power-fail trap
// (RULE3) power return traps through vector 24 again
// (RULE4) word access to odd address aborts and traps through vector 4
// (RULE5) bus cycle without slave answer in 10 us aborts, traps vector 4
// (RULE6) reserved instruction traps through vector 10
// (RULE7) io_trap_instr, emulator_trap_instr, software trap use vectors 020, 030, 034
// (RULE8) set trace_flag raises a trace trap through a fixed vector
// (RULE9) stack, parity, memory-management, floating-point errors each own a vector; stack errors use vector 4, shared with bus errors
// (RULE10) every trap pushes processor_status_word and program counter on the stack
// (RULE11) new program counter and status word load from two vector words
// (RULE12) return_from_interrupt and return_from_trace_trap pop both words back
// (RULE13) emulator and software trap decode ignores the low instruction byte
// (RULE14) pending traps served one at a time in fixed priority order
`timescale 1ns/1ps
module ptu_trap_unit
    import ptu_pkg::*;
#(
    parameter int HOLD_CYC = ptu_pkg::PTU_HOLD_CYC
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // core state
    input  wire logic             instrValid,
    input  wire logic [15:0]      instrWord,
    input  wire logic             atBoundary,
    input  wire logic [15:0]      curPc,
    input  wire logic [15:0]      curPsw,
    input  wire logic [15:0]      curSp,
    // error reports
    input  wire logic             reservedOp,
    input  wire logic             stackErr,
    input  wire logic             parityErr,
    input  wire logic             mmuErr,
    input  wire logic             fpuErr,
    input  wire logic             powerFail,
    input  wire ptu_pkg::ptu_bus_s busMon,
    // core control
    output ptu_pkg::ptu_ctx_s     ctx,
    output logic                  abortInstr,
    output logic                  trapBusy,
    output logic                  runEnable,
    // memory port
    output ptu_pkg::ptu_mem_s     mem,
    input  wire logic [15:0]      memRdata,
    input  wire logic             memAck
);
    import ptu_pkg::*;
    typedef enum {S_IDLE, S_PUSH_PSW, S_PUSH_PC, S_VEC_PC, S_VEC_PSW,
                  S_POP_PC, S_POP_PSW, S_LOAD} ptu_state_e;
    // event detection
    logic [PTU_NCAUSE-1:0] pend, next_pend;
    logic                  powerQ, next_powerQ;
    logic [PTU_HOLD_W-1:0] holdCnt, next_holdCnt;
    logic                  holdRun, next_holdRun;
    logic                  runEn, next_runEn;
    logic                  busBusy, next_busBusy;
    logic [PTU_TMO_W-1:0]  tmoCnt, next_tmoCnt;
    logic                  abortQ, next_abortQ;
    logic                  traceSkip, next_traceSkip;
    // sequencer
    ptu_state_e            state, next_state;
    logic [15:0]           sp, next_sp;
    logic [15:0]           vec, next_vec;
    logic [15:0]           savPc, next_savPc;
    logic [15:0]           savPsw, next_savPsw;
    ptu_mem_s              memQ, next_memQ;
    ptu_ctx_s              ctxQ, next_ctxQ;
    logic                  startRet;
    logic [PTU_NCAUSE-1:0] clr;
    logic [PTU_CIDX_W-1:0] sel;
    logic                  anyPend;

    always_comb
    begin
        logic [PTU_NCAUSE-1:0] set;
        logic                  oddWord;
        set = '0;
        oddWord = 1'b0;
        next_powerQ = powerFail;
        next_holdCnt = holdCnt;
        next_holdRun = holdRun;
        next_runEn = runEn;
        next_busBusy = busBusy;
        next_tmoCnt = tmoCnt;
        next_abortQ = 1'b0;
        next_traceSkip = traceSkip;
        // hold-up window: the handler gets its save time before run stops
        if (powerFail && !powerQ)
        begin
            set[PTU_C_POWER] = 1'b1; // (RULE1)
            next_holdCnt = PTU_HOLD_W'(HOLD_CYC - 1);
            next_holdRun = 1'b1;
        end
        else if (holdRun)
        begin
            if (holdCnt == '0)
            begin
                next_holdRun = 1'b0;
                next_runEn = 1'b0; // (RULE2)
            end
            else
                next_holdCnt = holdCnt - 1'b1;
        end
        if (!powerFail && powerQ)
        begin
            set[PTU_C_POWER] = 1'b1; // (RULE3)
            next_holdRun = 1'b0;
            next_runEn = 1'b1;
        end
        // bus watch: odd word address never starts the timer
        oddWord = busMon.start && busMon.word && busMon.addr[0];
        if (oddWord)
        begin
            set[PTU_C_BUS] = 1'b1; // (RULE4)
            next_abortQ = 1'b1;
            next_busBusy = 1'b0;
        end
        else if (busMon.start)
        begin
            next_busBusy = 1'b1;
            next_tmoCnt = '0;
        end
        else if (busBusy && busMon.ack)
            next_busBusy = 1'b0;
        else if (busBusy)
        begin
            if (tmoCnt == PTU_TMO_W'(PTU_TMO_CYC - 1))
            begin
                set[PTU_C_BUS] = 1'b1; // (RULE5)
                next_abortQ = 1'b1;
                next_busBusy = 1'b0;
            end
            else
                next_tmoCnt = tmoCnt + 1'b1;
        end
        set[PTU_C_STACK] = stackErr; // (RULE9)
        set[PTU_C_PARITY] = parityErr; // (RULE9)
        set[PTU_C_MMU] = mmuErr; // (RULE9)
        set[PTU_C_FPU] = fpuErr; // (RULE9)
        if (reservedOp)
        begin
            set[PTU_C_RSVD] = 1'b1; // (RULE6)
            next_abortQ = 1'b1;
        end
        if (instrValid)
        begin
            set[PTU_C_IOT] = (instrWord == PTU_OP_IOT); // (RULE7)
            set[PTU_C_EMT] = (instrWord[15:8] == PTU_OP_EMT_HI); // (RULE7) (RULE13)
            set[PTU_C_SWT] = (instrWord[15:8] == PTU_OP_SWT_HI); // (RULE7) (RULE13)
            set[PTU_C_BPT] = (instrWord == PTU_OP_BPT);
            // the instruction after a trace-trap return runs once untraced
            set[PTU_C_TRACE] = curPsw[PTU_PSW_TRACE] && !traceSkip; // (RULE8)
            next_traceSkip = (instrWord == PTU_OP_RTT);
        end
        // a new event beats the clear of its own flag
        next_pend = (pend & ~clr) | set;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend <= '0;
            powerQ <= 1'b0;
            holdCnt <= '0;
            holdRun <= 1'b0;
            runEn <= 1'b1;
            busBusy <= 1'b0;
            tmoCnt <= '0;
            abortQ <= 1'b0;
            traceSkip <= 1'b0;
        end
        else
        begin
            pend <= next_pend;
            powerQ <= next_powerQ;
            holdCnt <= next_holdCnt;
            holdRun <= next_holdRun;
            runEn <= next_runEn;
            busBusy <= next_busBusy;
            tmoCnt <= next_tmoCnt;
            abortQ <= next_abortQ;
            traceSkip <= next_traceSkip;
        end
    end

    // fixed priority: lowest index wins
    always_comb
    begin
        sel = '0;
        anyPend = 1'b0;
        for (int i = PTU_NCAUSE - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                sel = PTU_CIDX_W'(i); // (RULE14)
                anyPend = 1'b1;
            end
        end
    end
    assign startRet = instrValid &&
                      (instrWord == PTU_OP_RTI || instrWord == PTU_OP_RTT);
    always_comb
    begin
        next_state = state;
        next_sp = sp;
        next_vec = vec;
        next_savPc = savPc;
        next_savPsw = savPsw;
        next_ctxQ = ctxQ;
        next_ctxQ.load = 1'b0;
        clr = '0;
        case (state)
            S_IDLE:
            begin
                if (anyPend && atBoundary)
                begin
                    // one trap at a time; later ones wait in pend
                    clr[sel] = 1'b1; // (RULE14)
                    next_vec = PTU_VEC[sel];
                    next_savPc = curPc;
                    next_savPsw = curPsw;
                    next_sp = curSp - PTU_WORD_STEP;
                    next_state = S_PUSH_PSW;
                end
                else if (startRet)
                begin
                    next_sp = curSp;
                    next_state = S_POP_PC;
                end
            end
            S_PUSH_PSW:
            begin
                if (memAck)
                begin
                    next_sp = sp - PTU_WORD_STEP;
                    next_state = S_PUSH_PC; // (RULE10)
                end
            end
            S_PUSH_PC:
            begin
                if (memAck)
                    next_state = S_VEC_PC; // (RULE10)
            end
            S_VEC_PC:
            begin
                if (memAck)
                begin
                    next_ctxQ.pc = memRdata; // (RULE11)
                    next_state = S_VEC_PSW;
                end
            end
            S_VEC_PSW:
            begin
                if (memAck)
                begin
                    next_ctxQ.psw = memRdata; // (RULE11)
                    next_state = S_LOAD;
                end
            end
            S_POP_PC:
            begin
                if (memAck)
                begin
                    next_ctxQ.pc = memRdata; // (RULE12)
                    next_sp = sp + PTU_WORD_STEP;
                    next_state = S_POP_PSW;
                end
            end
            S_POP_PSW:
            begin
                if (memAck)
                begin
                    next_ctxQ.psw = memRdata; // (RULE12)
                    next_sp = sp + PTU_WORD_STEP;
                    next_state = S_LOAD;
                end
            end
            S_LOAD:
            begin
                next_ctxQ.load = 1'b1;
                next_ctxQ.sp = sp;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
        // memory request follows the state being entered
        next_memQ = '0;
        case (next_state)
            S_PUSH_PSW:
                next_memQ = '{req: 1'b1, we: 1'b1, addr: next_sp, wdata: next_savPsw};
            S_PUSH_PC:
                next_memQ = '{req: 1'b1, we: 1'b1, addr: next_sp, wdata: next_savPc};
            S_VEC_PC:
                next_memQ = '{req: 1'b1, we: 1'b0, addr: next_vec, wdata: 16'h0000};
            S_VEC_PSW:
                next_memQ = '{req: 1'b1, we: 1'b0, addr: next_vec + PTU_WORD_STEP,
                              wdata: 16'h0000};
            S_POP_PC, S_POP_PSW:
                next_memQ = '{req: 1'b1, we: 1'b0, addr: next_sp, wdata: 16'h0000};
            default: next_memQ = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            sp <= '0;
            vec <= '0;
            savPc <= '0;
            savPsw <= '0;
            memQ <= '0;
            ctxQ <= '0;
        end
        else
        begin
            state <= next_state;
            sp <= next_sp;
            vec <= next_vec;
            savPc <= next_savPc;
            savPsw <= next_savPsw;
            memQ <= next_memQ;
            ctxQ <= next_ctxQ;
        end
    end

    assign mem = memQ;
    assign ctx = ctxQ;
    assign abortInstr = abortQ;
    assign trapBusy = (state != S_IDLE);
    assign runEnable = runEn;
endmodule : ptu_trap_unit

//--- dv/ptu_trap_unit_properties.sv
// assertions on the trap unit ports
`timescale 1ns/1ps
module ptu_trap_unit_properties
    import ptu_pkg::*;
#(
    parameter int HOLD_CYC = 20
)(
    // watched ports
    input wire logic      clk,
    input wire logic      rst,
    input wire logic      reservedOp,
    input wire logic      powerFail,
    input wire logic [15:0] curPsw,
    input wire logic [15:0] curSp,
    input wire ptu_bus_s  busMon,
    input wire ptu_ctx_s  ctx,
    input wire logic      abortInstr,
    input wire logic      trapBusy,
    input wire logic      runEnable,
    input wire ptu_mem_s  mem,
    input wire logic      memAck
);
    logic [8:0]  tmo, next_tmo;
    logic        tmoOn, next_tmoOn;
    logic [15:0] pf, next_pf;
    // odd word starts abort at once, so they never arm the time-out watch
    always_comb
    begin
        next_tmo = busMon.start ? 9'h001 : (tmoOn ? tmo + 9'h001 : tmo);
        next_tmoOn = (busMon.start && !(busMon.word && busMon.addr[0]))
                     || (tmoOn && !busMon.ack && tmo != 9'h190);
        next_pf = !powerFail ? 16'h0000 : (pf == 16'hFFFF ? pf : pf + 16'h0001);
    end
    always_ff @(posedge clk)
    begin
        tmo <= rst ? 9'h000 : next_tmo;
        tmoOn <= rst ? 1'b0 : next_tmoOn;
        pf <= rst ? 16'h0000 : next_pf;
    end
    AST_ODD_ABORT: assert property (@(posedge clk) disable iff (rst)
        busMon.start && busMon.word && busMon.addr[0] |=> abortInstr) else $error("no odd abort");
    AST_RSVD_ABORT: assert property (@(posedge clk) disable iff (rst)
        reservedOp |=> abortInstr) else $error("no reserved abort");
    AST_TMO_ABORT: assert property (@(posedge clk) disable iff (rst)
        tmoOn && tmo == 9'h190 |-> ##[0:3] abortInstr) else $error("no timeout abort");
    AST_FIRST_ACCESS: assert property (@(posedge clk) disable iff (rst)
        $rose(trapBusy) |-> mem.req && ((mem.we && mem.addr == $past(curSp) - 16'h0002
        && mem.wdata == $past(curPsw)) || (!mem.we && mem.addr == $past(curSp))))
        else $error("bad first access");
    AST_PC_PUSH: assert property (@(posedge clk) disable iff (rst)
        (mem.req && mem.we && memAck) ##1 (mem.req && mem.we)
        |-> mem.addr == $past(mem.addr) - 16'h0002) else $error("bad push address");
    AST_VEC_PAIR: assert property (@(posedge clk) disable iff (rst)
        (mem.req && !mem.we && memAck) ##1 (mem.req && !mem.we)
        |-> mem.addr == $past(mem.addr) + 16'h0002) else $error("bad second read");
    AST_LOAD_PULSE: assert property (@(posedge clk) disable iff (rst)
        $rose(ctx.load) |-> $past(trapBusy, 2) ##1 !ctx.load) else $error("bad load");
    AST_REQ_HOLD: assert property (@(posedge clk) disable iff (rst)
        mem.req && !memAck |=> mem.req && $stable(mem.addr) && $stable(mem.we))
        else $error("request dropped");
    AST_RUN_HOLD: assert property (@(posedge clk) disable iff (rst)
        powerFail && pf < HOLD_CYC |-> runEnable) else $error("run stopped early");
    AST_RUN_DROP: assert property (@(posedge clk) disable iff (rst)
        pf == HOLD_CYC + 2 |-> !runEnable) else $error("run not stopped");
    AST_RUN_BACK: assert property (@(posedge clk) disable iff (rst)
        $fell(powerFail) |-> ##[1:2] runEnable) else $error("run not resumed");
endmodule : ptu_trap_unit_properties
bind ptu_trap_unit ptu_trap_unit_properties #(.HOLD_CYC(HOLD_CYC)) ptu_trap_unit_properties_i (
    .clk, .rst, .reservedOp, .powerFail, .curPsw, .curSp, .busMon, .ctx, .abortInstr,
    .trapBusy, .runEnable, .mem, .memAck);

//--- dv/ptu_mem_model.sv
// memory and bus slave model facing the trap unit
`timescale 1ns/1ps
module ptu_mem_model
    import ptu_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // memory port
    input  wire ptu_mem_s  mem,
    output logic [15:0]    memRdata,
    output logic           memAck,
    // answer delay in cycles
    input  wire logic [3:0] lat
);
    logic [15:0] store [512];
    logic [3:0]  waitCnt = 4'h0;
    initial memRdata = 16'h0000;
    initial memAck = 1'b0;
    initial for (int i = 0; i < 512; i++) store[i] = 16'hA000 | 16'(i * 2);
    // read data toggles when idle so a stale word is never mistaken for an answer
    always @(posedge clk)
    begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        waitCnt <= 4'h0;
        if (!rst && mem.req && !memAck)
        begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt >= lat)
            begin
                memAck <= 1'b1;
                waitCnt <= 4'h0;
                memRdata <= store[mem.addr[9:1]];
                if (mem.we)
                    store[mem.addr[9:1]] <= mem.wdata;
            end
        end
    end
endmodule : ptu_mem_model

//--- dv/ptu_trap_unit_tb.sv
// self-checking bench of the trap unit
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module ptu_trap_unit_tb;
    import ptu_pkg::*;
    localparam int HOLD = 20;
    logic        clk, rst, instrValid, atBoundary, reservedOp, powerFail, sawAbort;
    logic        stackErr, parityErr, mmuErr, fpuErr, abortInstr, trapBusy, runEnable, memAck;
    logic [15:0] instrWord, curPc, curPsw, curSp, memRdata;
    logic [3:0]  lat;
    ptu_bus_s    busMon;
    ptu_ctx_s    ctx;
    ptu_mem_s    mem;
    int          bad_count, n_tests, runCnt;
    ptu_trap_unit #(.HOLD_CYC(HOLD)) ptu_trap_unit_i (
        .clk, .rst, .instrValid, .instrWord, .atBoundary, .curPc, .curPsw, .curSp,
        .reservedOp, .stackErr, .parityErr, .mmuErr, .fpuErr, .powerFail, .busMon,
        .ctx, .abortInstr, .trapBusy, .runEnable, .mem, .memRdata, .memAck);
    ptu_mem_model ptu_mem_model_i (.clk, .rst, .mem, .memRdata, .memAck, .lat);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        if (abortInstr === 1'b1)
            sawAbort <= 1'b1;
    // edges that ran on after mains loss, so an early stop is caught
    always @(posedge clk)
        if (powerFail !== 1'b1)
            runCnt <= 0;
        else if (runEnable === 1'b1)
            runCnt <= runCnt + 1;
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic wait_load;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (ctx.load !== 1'b1 && n < 600);
        if (ctx.load !== 1'b1)
        begin
            `CHK(ctx.load, 1'b1)
            report_and_stop();
        end
    endtask : wait_load
    task automatic expect_trap(input logic [15:0] vec);
        logic [15:0] a;
        wait_load();
        `CHK(ctx.pc, 16'hA000 | vec)
        `CHK(ctx.psw, 16'hA000 | (vec + 16'h0002))
        `CHK(ctx.sp, curSp - 16'h0004)
        a = curSp - 16'h0002;
        `CHK(ptu_mem_model_i.store[a[9:1]], curPsw)
        a = curSp - 16'h0004;
        `CHK(ptu_mem_model_i.store[a[9:1]], curPc)
    endtask : expect_trap
    task automatic give_instr(input logic [15:0] w);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w;
        @(posedge clk);
        instrValid <= 1'b0;
    endtask : give_instr
    task automatic pulse_err(input logic [3:0] e);
        @(posedge clk);
        {stackErr, parityErr, mmuErr, fpuErr} <= e;
        @(posedge clk);
        {stackErr, parityErr, mmuErr, fpuErr} <= 4'h0;
    endtask : pulse_err
    task automatic s_swtraps;
        logic [15:0] w [4] = '{16'h0004, 16'h88A5, 16'h89FF, 16'h0003};
        logic [15:0] v [4] = '{16'h0010, 16'h0018, 16'h001C, 16'h000C};
        for (int i = 0; i < 4; i++)
        begin
            give_instr(w[i]);
            expect_trap(v[i]);
        end
    endtask : s_swtraps
    task automatic s_aborts;
        for (int k = 0; k < 3; k++)
        begin
            sawAbort = 1'b0;
            @(posedge clk);
            reservedOp <= (k == 0);
            busMon <= '{start: k != 0, word: 1'b1, addr: 16'h0100 | 16'(k == 1), ack: 1'b0};
            @(posedge clk);
            reservedOp <= 1'b0;
            busMon.start <= 1'b0;
            busMon.ack <= (k == 1);
            @(posedge clk);
            busMon.ack <= 1'b0;
            expect_trap(k == 0 ? 16'h0008 : 16'h0004);
            `CHK(sawAbort, 1'b1)
        end
    endtask : s_aborts
    task automatic s_errors;
        logic [15:0] v [4] = '{16'h0004, 16'h004C, 16'h00A8, 16'h00A4};
        lat = 4'h3;
        for (int i = 0; i < 4; i++)
        begin
            pulse_err(4'b1000 >> i);
            expect_trap(v[i]);
        end
        lat = 4'h0;
    endtask : s_errors
    task automatic s_priority;
        @(posedge clk);
        atBoundary <= 1'b0;
        pulse_err(4'b1001);
        @(posedge clk);
        atBoundary <= 1'b1;
        expect_trap(16'h0004);
        expect_trap(16'h00A4);
    endtask : s_priority
    task automatic s_trace;
        @(posedge clk);
        curPsw <= 16'h0010;
        give_instr(16'h1234);
        expect_trap(16'h000C);
        @(posedge clk);
        curPsw <= 16'h00E0;
    endtask : s_trace
    task automatic s_return;
        logic [15:0] op [2] = '{PTU_OP_RTI, PTU_OP_RTT};
        give_instr(16'h0004);
        expect_trap(16'h0010);
        @(posedge clk);
        curSp <= 16'h02FC;
        for (int i = 0; i < 2; i++)
        begin
            give_instr(op[i]);
            wait_load();
            `CHK(ctx.pc, 16'h0150)
            `CHK(ctx.psw, 16'h00E0)
            `CHK(ctx.sp, 16'h0300)
        end
        @(posedge clk);
        curSp <= 16'h0300;
    endtask : s_return
    task automatic s_power;
        int n;
        @(posedge clk);
        powerFail <= 1'b1;
        expect_trap(16'h0014);
        `CHK(runEnable, 1'b1)
        n = 0;
        while (runEnable === 1'b1 && n < 3 * HOLD)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(runEnable, 1'b0)
        `CHK(runCnt >= HOLD, 1'b1)
        @(posedge clk);
        powerFail <= 1'b0;
        expect_trap(16'h0014);
        `CHK(runEnable, 1'b1)
    endtask : s_power
    initial
    begin
        rst = 1'b1;
        {instrValid, atBoundary, reservedOp, powerFail, sawAbort} = 5'h00;
        {stackErr, parityErr, mmuErr, fpuErr} = 4'h0;
        instrWord = 16'h0000;
        curPc = 16'h0150;
        curPsw = 16'h00E0;
        curSp = 16'h0300;
        busMon = '0;
        lat = 4'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        atBoundary <= 1'b1;
        s_swtraps();
        s_aborts();
        s_errors();
        s_priority();
        s_trace();
        s_return();
        s_power();
        report_and_stop();
    end
endmodule : ptu_trap_unit_tb
